// ### sim/tb.sv
// Directed bench for the unit over its APB port.
`timescale 1ns/10ps
`include "tcc_regs.svh"
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
$display("wrong value %s exp %h got %h", n, e, a); end end
module tb
  import tcc_pkg::*;
;
  logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pin_ext = 0, run = 0;
  logic [1:0]  mode = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, er, pin_out, pin_oe, irq, ccq, cca, mzq, mza;
  logic [15:0] max_value, cv;
  tcc_cnt_t    cnt;
  tcc_evt_t    evt;
  int          n_fail = 0, n_compared = 0;
  always #50 ref_clk = ~ref_clk;
  tcc_unit tcc_unit_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .cnt, .max_value, .pin_in(pin_oe ? pin_out : pin_ext), .pin_out,
    .pin_oe, .evt, .dma_cc_req(ccq), .dma_cc_ack(cca), .dma_mz_req(mzq), .dma_mz_ack(mza), .irq);
  tcc_far tcc_far_i (.ref_clk, .rst, .run, .mode, .max_value, .cc_req(ccq), .mz_req(mzq), .cnt,
    .cc_ack(cca), .mz_ack(mza));
  task automatic test_done();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    `CHK(n, e, rd)
  endtask
  // Edges from a step with value v to the sampled match pulse.
  task automatic per(input logic [15:0] v, input int e);
    int k;
    k = 0;
    do begin
      gap(1);
      k++;
    end while (!(cnt.step === 1'b1 && cnt.value === v) && k < 300);
    if (!(cnt.step === 1'b1 && cnt.value === v)) begin
      n_fail++;
      test_done();
    end
    k = 0;
    do begin
      gap(1);
      k++;
    end while (evt.match !== 1'b1 && k < 300);
    if (evt.match !== 1'b1) begin
      n_fail++;
      test_done();
    end
    `CHK("period", e, k)
  endtask
  initial begin
    gap(6);
    rst <= 0;
    gap(1);
    `CHK("oe", 1'b1, pin_oe)
    `CHK("max", 16'hFFFF, max_value)
    rdc("unmapped", 12'h01C, 32'h0000_0000);
    `CHK("err", 1'b1, er)
    apb(1, `TCC_OFF_MAX, 16'h0009);
    apb(1, `TCC_OFF_DATA, 16'h0003);
    gap(2);
    run <= 1;
    per(16'h0000, 4);
    gap(12);
    run <= 0;
    rdc("flags", `TCC_OFF_FLAG, 4'h7);
    rdc("buf", `TCC_OFF_STATUS, 16'h0003);
    apb(1, `TCC_OFF_INTEN, 4'h1);
    gap(2);
    `CHK("irq", 1'b1, irq)
    apb(1, `TCC_OFF_FLAG, 4'hF);
    rdc("clear", `TCC_OFF_FLAG, 4'h0);
    `CHK("irq", 1'b0, irq)
    $display("end up");
    apb(1, `TCC_OFF_CTRL, 10'h040);
    apb(1, `TCC_OFF_DATA, 16'h0006);
    rdc("hold", `TCC_OFF_STATUS, 16'h0003);
    run <= 1;
    per(16'h0000, 7);
    run <= 0;
    apb(1, `TCC_OFF_CTRL, 10'h140);
    apb(1, `TCC_OFF_DATA, 16'h0008);
    run <= 1;
    gap(12);
    run <= 0;
    rdc("reserved", `TCC_OFF_STATUS, 16'h0006);
    $display("end buffer");
    apb(1, `TCC_OFF_CTRL, 10'h000);
    apb(1, `TCC_OFF_DATA, 16'h0006);
    apb(1, `TCC_OFF_DMAEN, 2'h3);
    mode <= 1;
    run <= 1;
    per(16'h0009, 4);
    gap(12);
    run <= 0;
    $display("end down");
    apb(1, `TCC_OFF_DMAEN, 2'h0);
    apb(1, `TCC_OFF_CTRL, 10'h013);
    apb(1, `TCC_OFF_FLAG, 4'hF);
    run <= 1;
    `CHK("oe", 1'b0, pin_oe)
    for (int i = 0; i < 2; i++) begin
      pin_ext <= 1;
      gap(3);
      cv = cnt.value;
      gap(5);
      pin_ext <= 0;
      gap(2);
      rdc("capture", `TCC_OFF_FLAG, i ? 4'h9 : 4'h1);
      rdc("data", `TCC_OFF_DATA, {16'h0000, cv});
    end
    apb(1, `TCC_OFF_FLAG, 4'hF);
    for (int i = 0; i < 2; i++) begin
      apb(1, `TCC_OFF_CTRL, i ? 10'h011 : 10'h013);
      #20 pin_ext <= 1;
      #20 pin_ext <= 0;
      gap(8);
      rdc("short", `TCC_OFF_FLAG, i ? 4'h1 : 4'h0);
    end
    apb(1, `TCC_OFF_FLAG, 4'hF);
    apb(1, `TCC_OFF_CTRL, 10'h015);
    apb(1, `TCC_OFF_CTRL, 10'h215);
    rdc("swrise", `TCC_OFF_FLAG, 4'h1);
    apb(1, `TCC_OFF_CTRL, 10'h025);
    rdc("swfall", `TCC_OFF_FLAG, 4'h9);
    $display("end capture");
    test_done();
  end
endmodule
bind tcc_unit tcc_unit_sva tcc_unit_sva_i (.ref_clk, .rst, .cnt, .max_value, .pin_out,
  .pin_oe, .evt, .dma_cc_req, .dma_mz_req, .dma_mz_ack);

// ### sim/tcc_far.sv
// Counter block and DMA acceptor model at the far side of the unit.
`timescale 1ns/10ps
module tcc_far
  import tcc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] max_value,
  input  wire logic        cc_req,
  input  wire logic        mz_req,
  output tcc_cnt_t         cnt,
  output logic             cc_ack,
  output logic             mz_ack
);
  // Accepts are one-cycle pulses, so a request held high is taken on every second clock.
  always_ff @(posedge ref_clk) begin
    cc_ack <= !rst && cc_req && !cc_ack;
    mz_ack <= !rst && mz_req && !mz_ack;
    cnt.mode <= mode;
    cnt.running <= run && !rst;
    cnt.step <= run && !rst;
    if (rst || !run)
      cnt.value <= (mode == 2'h1) ? max_value : 16'h0000;
    else if (cnt.step && mode == 2'h1)
      cnt.value <= (cnt.value == 16'h0000) ? max_value : cnt.value - 16'h0001;
    else if (cnt.step)
      cnt.value <= (cnt.value >= max_value) ? 16'h0000 : cnt.value + 16'h0001;
  end
endmodule

// ### sim/tcc_unit_sva.sv
// Checker for the event, pin and DMA outputs of the unit.
`timescale 1ns/10ps
module tcc_unit_sva
  import tcc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire tcc_cnt_t    cnt,
  input wire logic [15:0] max_value,
  input wire logic        pin_out,
  input wire logic        pin_oe,
  input wire tcc_evt_t    evt,
  input wire logic        dma_cc_req,
  input wire logic        dma_mz_req,
  input wire logic        dma_mz_ack
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_zero; cnt.step && cnt.value == 16'h0000 && pin_oe |=> evt.cnt_zero; endproperty
  a_zero: assert property (p_zero) else $error("zero missed");
  property p_max; cnt.step && cnt.value == max_value && pin_oe |=> evt.cnt_max; endproperty
  a_max: assert property (p_max) else $error("max missed");
  property p_zval; evt.cnt_zero |-> $past(cnt.step) && $past(cnt.value) == 16'h0000; endproperty
  a_zval: assert property (p_zval) else $error("bad zero");
  property p_match; evt.match |-> $past(cnt.step) && pin_oe; endproperty
  a_match: assert property (p_match) else $error("bad match");
  property p_tog; evt.match |-> pin_out != $past(pin_out); endproperty
  a_tog: assert property (p_tog) else $error("no toggle");
  property p_ccdma; $rose(dma_cc_req) && pin_oe |-> evt.match; endproperty
  a_ccdma: assert property (p_ccdma) else $error("bad cc req");
  property p_mzdma;
    $rose(dma_mz_req) |-> ($past(cnt.mode) == 2'h1 ? evt.cnt_zero : evt.cnt_max);
  endproperty
  a_mzdma: assert property (p_mzdma) else $error("bad mz req");
  property p_ack; dma_mz_ack |=> !dma_mz_req || evt.cnt_max || evt.cnt_zero; endproperty
  a_ack: assert property (p_ack) else $error("req held");
endmodule

// ### src/tcc_pkg.sv
// Types shared by the compare/capture unit.
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_CNT_UP   = 2'h0,
    TCC_CNT_DOWN = 2'h1,
    TCC_CNT_UPDN = 2'h2
  } tcc_cnt_mode_t;

  typedef enum logic [2:0] {
    TCC_BUF_WRITE = 3'h0,
    TCC_BUF_ZERO  = 3'h1,
    TCC_BUF_MAX   = 3'h2,
    TCC_BUF_ZMAX  = 3'h3,
    TCC_BUF_MATCH = 3'h4
  } tcc_buf_mode_t;

  typedef struct packed {
    logic [15:0] value;
    logic        step;
    logic        running;
    logic [1:0]  mode;
  } tcc_cnt_t;

  typedef struct packed {
    logic        match;
    logic        cnt_max;
    logic        cnt_zero;
  } tcc_evt_t;

  // Members run from the top bit down, so mode lands on bit 0 of the control word.
  typedef struct packed {
    logic        sw_trg;
    logic [2:0]  buf_mode;
    logic [1:0]  edge_sel;
    logic [1:0]  trg_sel;
    logic        sync;
    logic        mode;
  } tcc_ctrl_t;

  typedef struct packed {
    tcc_ctrl_t   ctrl;
    logic [15:0] data;
    logic [15:0] cmp_buf;
    logic [15:0] max_val;
    logic [3:0]  flag;
    logic [3:0]  int_en;
    logic [1:0]  dma_en;
    logic        dma_cc_req;
    logic        dma_mz_req;
    logic        buf_pend;
    tcc_evt_t    evt;
    logic        tout;
    logic        pin_oe;
    logic        irq;
    logic [2:0]  pin_sync;
    logic [2:0]  rise_sync;
    logic [2:0]  fall_sync;
    logic        sw_prev;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tcc_state_t;
endpackage

// ### src/tcc_regs.svh
// Register offsets, field positions and reset values of the compare/capture unit.
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
`define TCC_OFF_CTRL     12'h000
`define TCC_OFF_DATA     12'h004
`define TCC_OFF_FLAG     12'h008
`define TCC_OFF_DMAEN    12'h00C
`define TCC_OFF_INTEN    12'h010
`define TCC_OFF_MAX      12'h014
`define TCC_OFF_STATUS   12'h018
`define TCC_CTRL_MODE    0
`define TCC_CTRL_SYNC    1
`define TCC_CTRL_TRG_LO  2
`define TCC_CTRL_EDG_LO  4
`define TCC_CTRL_BUF_LO  6
`define TCC_CTRL_SWTRG   9
`define TCC_FLG_CC       0
`define TCC_FLG_MAX      1
`define TCC_FLG_ZERO     2
`define TCC_FLG_OVW      3
`define TCC_DMA_CC       0
`define TCC_DMA_MZ       1
`define TCC_RST_MAX      16'hFFFF
`define TCC_ZERO_VALUE   16'h0000
`endif

// ### src/tcc_unit.sv
// One compare/capture circuit of a 16-bit timer channel with an APB register port.
// Function
// RULE1: compare mode: counter equal to buffered value pulses match and sets the flag.
// RULE2: compare mode: counter reaching maximum sets the counter-maximum flag.
// RULE3: compare mode: counter reaching 0x0000 sets the counter-zero flag.
// RULE4: shared pin is timer output in compare mode, capture input in capture mode.
// RULE5: compare flag timing follows the counter: up CC+1, down MAX-CC+1 clocks.
// RULE6: written compare data moves into a buffer at a time set by load mode.
// RULE7: data register holds compare value, or the captured counter in capture mode.
// RULE8: compare flag set with compare DMA enabled issues a DMA request.
// RULE9: max/zero DMA enable requests maximum reload on max (up) or zero (down).
// RULE10: DMA descriptor for reloads uses fixed destination, halfword, step two.
// RULE11: DMA controller must be programmed and enabled before requests are served.
// RULE12: capture trigger source and active edge come from two 2-bit fields.
// RULE13: trigger edge while counting latches counter and sets the flag together.
// RULE14: capture while the flag is still set raises the overwrite flag.
// RULE15: sync select 1 synchronises the trigger; short pulses are missed.
// RULE16: sync select 0 catches pulses shorter than one clock.
// RULE17: match, maximum and zero events drive the timer output generator; here only match toggles pin_out.
// RULE18: mode bit 0 selects compare, 1 selects capture.
// RULE19: compared and captured value comes from the 16-bit up/down counter.
// RULE20: flags clear on a write of 1; DMA requests drop on acceptance.
// RULE21: interrupt needs a set flag with its enable; load modes above 4 reserved.
`timescale 1ns/10ps
`include "tcc_regs.svh"
module tcc_unit
  import tcc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire tcc_cnt_t    cnt,
  output logic [15:0]      max_value,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe,
  output tcc_evt_t         evt,
  output logic             dma_cc_req,
  input  wire logic        dma_cc_ack,
  output logic             dma_mz_req,
  input  wire logic        dma_mz_ack,
  output logic             irq
);
  tcc_state_t st;
  tcc_state_t next_st;
  logic       rise_tgl;
  logic       fall_tgl;

  // Asynchronous catchers: a pin edge of any width flips a toggle that the
  // count clock later sees, so no pulse is lost however short it is.
  always_ff @(posedge pin_in or posedge rst) begin
    if (rst) begin
      rise_tgl <= 1'b0;
    end else begin
      rise_tgl <= ~rise_tgl; // RULE16
    end
  end

  always_ff @(negedge pin_in or posedge rst) begin
    if (rst) begin
      fall_tgl <= 1'b0;
    end else begin
      fall_tgl <= ~fall_tgl; // RULE16
    end
  end

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall);
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction

  function automatic logic [31:0] rd_mux(input tcc_state_t s, input logic [11:0] a);
    rd_mux = 32'h0000_0000;
    unique case (a)
      `TCC_OFF_CTRL:   rd_mux = {22'h00_0000, s.ctrl};
      `TCC_OFF_DATA:   rd_mux = {16'h0000, s.data}; // RULE7
      `TCC_OFF_FLAG:   rd_mux = {28'h000_0000, s.flag};
      `TCC_OFF_DMAEN:  rd_mux = {30'h0000_0000, s.dma_en};
      `TCC_OFF_INTEN:  rd_mux = {28'h000_0000, s.int_en};
      `TCC_OFF_MAX:    rd_mux = {16'h0000, s.max_val};
      `TCC_OFF_STATUS: rd_mux = {16'h0000, s.cmp_buf};
      default:         rd_mux = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `TCC_OFF_CTRL) || (a == `TCC_OFF_DATA) || (a == `TCC_OFF_FLAG)
          || (a == `TCC_OFF_DMAEN) || (a == `TCC_OFF_INTEN)
          || (a == `TCC_OFF_MAX) || (a == `TCC_OFF_STATUS);
  endfunction

  logic        acc;
  logic        wr;
  logic        hit_match;
  logic        hit_max;
  logic        hit_zero;
  logic        rise_s;
  logic        fall_s;
  logic        trg;
  logic        cap;
  logic        load_buf;
  logic [3:0]  set_flag;
  logic [3:0]  clr_flag;
  logic        data_wr;

  always_comb begin
    next_st = st;
    acc     = psel & penable;
    wr      = acc & pwrite & st.pready;
    data_wr = wr & (paddr == `TCC_OFF_DATA);
    // The counter only counts as reaching a value on the clock it steps.
    hit_match = ~st.ctrl.mode & cnt.step & (cnt.value == st.cmp_buf); // RULE1 RULE5 RULE19
    hit_max   = ~st.ctrl.mode & cnt.step & (cnt.value == st.max_val); // RULE2
    hit_zero  = ~st.ctrl.mode & cnt.step & (cnt.value == `TCC_ZERO_VALUE); // RULE3

    next_st.pin_sync  = {st.pin_sync[1:0], pin_in};
    next_st.rise_sync = {st.rise_sync[1:0], rise_tgl};
    next_st.fall_sync = {st.fall_sync[1:0], fall_tgl};
    next_st.sw_prev   = st.ctrl.sw_trg;
    rise_s = 1'b0;
    fall_s = 1'b0;
    unique case (st.ctrl.trg_sel) // RULE12
      2'h0: begin
        if (st.ctrl.sync) begin
          // Edge taken only while stages two and three differ.
          rise_s = (st.pin_sync[1] == st.pin_sync[2]) ? 1'b0 : st.pin_sync[1]; // RULE15
          fall_s = (st.pin_sync[1] == st.pin_sync[2]) ? 1'b0 : ~st.pin_sync[1]; // RULE15
        end else begin
          rise_s = st.rise_sync[1] ^ st.rise_sync[2]; // RULE16
          fall_s = st.fall_sync[1] ^ st.fall_sync[2]; // RULE16
        end
      end
      2'h1: begin
        rise_s = st.ctrl.sw_trg & ~st.sw_prev;
        fall_s = ~st.ctrl.sw_trg & st.sw_prev;
      end
      default: begin
        rise_s = 1'b0;
        fall_s = 1'b0;
      end
    endcase
    trg = edge_hit(st.ctrl.edge_sel, rise_s, fall_s); // RULE12
    cap = st.ctrl.mode & cnt.running & trg; // RULE13 RULE18

    set_flag = 4'h0;
    set_flag[`TCC_FLG_CC]   = hit_match | cap; // RULE1 RULE13
    set_flag[`TCC_FLG_MAX]  = hit_max; // RULE2
    set_flag[`TCC_FLG_ZERO] = hit_zero; // RULE3
    set_flag[`TCC_FLG_OVW]  = cap & st.flag[`TCC_FLG_CC]; // RULE14
    clr_flag = (wr && paddr == `TCC_OFF_FLAG) ? pwdata[3:0] : 4'h0;
    next_st.flag = (st.flag & ~clr_flag) | set_flag; // RULE20

    if (data_wr && !st.ctrl.mode) begin
      next_st.data = pwdata[15:0];
    end
    if (cap) begin
      next_st.data = cnt.value; // RULE7 RULE13
    end
    if (data_wr && !st.ctrl.mode) begin
      next_st.buf_pend = 1'b1;
    end

    load_buf = 1'b0;
    unique case (st.ctrl.buf_mode) // RULE6
      TCC_BUF_WRITE: load_buf = 1'b1;
      TCC_BUF_ZERO:  load_buf = hit_zero;
      TCC_BUF_MAX:   load_buf = hit_max;
      TCC_BUF_ZMAX:  load_buf = hit_zero | hit_max;
      TCC_BUF_MATCH: load_buf = hit_match;
      default:       load_buf = 1'b0; // RULE21
    endcase
    if (load_buf && st.buf_pend && !st.ctrl.mode) begin
      next_st.cmp_buf  = st.data; // RULE6
      next_st.buf_pend = data_wr;
    end

    // A fresh event in the acknowledge cycle keeps the request alive.
    if (dma_cc_ack) begin
      next_st.dma_cc_req = 1'b0; // RULE20
    end
    if (st.dma_en[`TCC_DMA_CC] && set_flag[`TCC_FLG_CC]) begin
      next_st.dma_cc_req = 1'b1; // RULE8
    end
    if (dma_mz_ack) begin
      next_st.dma_mz_req = 1'b0; // RULE20
    end
    if (st.dma_en[`TCC_DMA_MZ]
        && ((cnt.mode == TCC_CNT_DOWN) ? hit_zero : hit_max)) begin
      next_st.dma_mz_req = 1'b1; // RULE9
    end

    next_st.evt.match    = hit_match; // RULE17
    next_st.evt.cnt_max  = hit_max; // RULE17
    next_st.evt.cnt_zero = hit_zero; // RULE17
    if (hit_match) begin
      next_st.tout = ~st.tout; // RULE17
    end
    next_st.pin_oe = ~st.ctrl.mode; // RULE4
    next_st.irq    = |(next_st.flag & st.int_en); // RULE21

    if (wr) begin
      unique case (paddr)
        `TCC_OFF_CTRL:  next_st.ctrl    = pwdata[9:0];
        `TCC_OFF_DMAEN: next_st.dma_en  = pwdata[1:0];
        `TCC_OFF_INTEN: next_st.int_en  = pwdata[3:0];
        `TCC_OFF_MAX:   next_st.max_val = pwdata[15:0];
        default:        next_st.max_val = st.max_val;
      endcase
    end

    // One wait state: ready rises on the second access cycle, then drops.
    next_st.pready  = acc & ~st.pready;
    next_st.pslverr = acc & ~st.pready & ~mapped(paddr);
    next_st.prdata  = (acc && !st.pready && !pwrite) ? rd_mux(st, paddr) : 32'h0000_0000;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st         <= '0;
      st.max_val <= `TCC_RST_MAX;
      st.pin_oe  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign pready     = st.pready;
  assign prdata     = st.prdata;
  assign pslverr    = st.pslverr;
  assign max_value  = st.max_val;
  assign pin_out    = st.tout; // RULE4
  assign pin_oe     = st.pin_oe;
  assign evt        = st.evt;
  assign dma_cc_req = st.dma_cc_req;
  assign dma_mz_req = st.dma_mz_req;
  assign irq        = st.irq;
endmodule
